// *** common/rate_gen_if.sv ***
// Interface between the configuration top and the line clock generator.
`timescale 1ns/1ps
interface rate_gen_if;
  logic enable;
  logic [31:0] rate_bps;
  logic tick;
  modport ctrl (output enable, output rate_bps, input tick);
  modport gen (input enable, input rate_bps, output tick);
endinterface

// *** common/serial_cfg_params.svh ***
// Constants for the serial port configuration block: offsets, fields, resets and timing.
// Function
// - Four detection settings: both, interface only, connector only, neither detected.
// - Connector role comes from the cable when detection covers the connector.
// - Line rate applies only in the DCE role, which supplies the clock.
// - Fixed rates 2400 bps up to 8 Mbps in thirteen steps.
// - Custom rate accepts any bps value between 2400 and 8000000.
// - Line rate setting resets to 64000 bps.
// - Layer 2 mode picks the DTE or DCE address for command frames.
// - Automatic layer 2 mode follows the configured or detected connector role.
// - With lead checking on, partner I or CTS lead drives layer 1 state.
// - With lead checking off, the default, layer 1 state stays up.
// - Both link ends should use the same lead checking setting.
// - Unknown is reported when no cable or a non-detecting cable is attached.
// - A detecting X.21 cable selects terminated X.21; unterminated needs manual setting.
// - Connector role maps the port pins as DTE or as DCE.
// - Interface type none marks the port unused.
`ifndef SERIAL_CFG_PARAMS_SVH
`define SERIAL_CFG_PARAMS_SVH
`define ADDR_W 4
`define OFF_CONFIG 4'h0
`define OFF_RATE_SEL 4'h1
`define OFF_CUSTOM_RATE 4'h2
`define OFF_STATUS 4'h3
`define OFF_IRQ_STAT 4'h4
`define OFF_IRQ_MASK 4'h5
`define OFF_HDLC_ADDR 4'h6
// CONFIG fields.
`define CFG_DETECT_LSB 0
`define CFG_IFTYPE_LSB 2
`define CFG_ROLE_LSB 6
`define CFG_L2MODE_LSB 8
`define CFG_LEADS_BIT 10
`define CFG_RESET 32'h0000_0000
`define RATE_SEL_RESET 4'h5
`define CUSTOM_RATE_RESET 32'h0000_FA00
`define RATE_MIN_BPS 32'h0000_0960
`define RATE_MAX_BPS 32'h007A_1200
`define HDLC_ADDR_DTE 8'h03
`define HDLC_ADDR_DCE 8'h01
`define CLK_HZ 50000000
`define IRQ_L1_CHANGE 0
`define IRQ_CABLE_CHANGE 1
`endif

// *** common/serial_cfg_pkg.sv ***
// Types for the serial port configuration block.
package serial_cfg_pkg;
  typedef enum logic [1:0] {
    DET_BOTH = 2'h0, DET_IFTYPE = 2'h1, DET_ROLE = 2'h2, DET_MANUAL = 2'h3
  } detect_t;
  typedef enum logic [3:0] {
    IF_UNKNOWN = 4'h0, IF_NONE = 4'h1, IF_X21_TERM = 4'h2, IF_V35 = 4'h3, IF_V36 = 4'h4,
    IF_X21BIS = 4'h5, IF_X21_UNTERM = 4'h6, IF_RS449 = 4'h7, IF_RS530 = 4'h8
  } iftype_t;
  typedef enum logic [1:0] {
    ROLE_UNKNOWN = 2'h0, ROLE_DTE = 2'h1, ROLE_DCE = 2'h2
  } role_t;
  typedef enum logic [1:0] {
    L2_AUTO = 2'h0, L2_DTE = 2'h1, L2_DCE = 2'h2
  } l2mode_t;
endpackage

// *** src/rate_gen.sv ***
// Fractional line rate generator giving one enable pulse per line clock half period.
`timescale 1ns/1ps
`include "serial_cfg_params.svh"
module rate_gen #(
  parameter int CLK_HZ = `CLK_HZ
) (
  input wire logic clk,
  input wire logic rst,
  rate_gen_if.gen rg
);
  // The top line rate needs two ticks per line period, so slower clocks are refused.
  if (CLK_HZ < 16000000) begin : g_clk_too_slow
    $error("rate_gen: clock too slow for the top line rate");
  end
  localparam logic [33:0] MOD = 34'(CLK_HZ);
  logic [33:0] acc_reg;
  logic [33:0] acc_next;
  logic tick_reg;
  // Each clock adds twice the rate; wrap past the clock rate gives a tick.
  always_comb begin
    acc_next = acc_reg + {1'b0, rg.rate_bps, 1'b0};
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg <= 34'h0;
      tick_reg <= 1'b0;
    end else if (!rg.enable) begin
      acc_reg <= 34'h0;
      tick_reg <= 1'b0;
    end else if (acc_next >= MOD) begin
      acc_reg <= acc_next - MOD;
      tick_reg <= 1'b1;
    end else begin
      acc_reg <= acc_next;
      tick_reg <= 1'b0;
    end
  end
  assign rg.tick = tick_reg;
endmodule // rate_gen

// *** src/serial_cfg.sv ***
// Serial WAN port configuration, line role, clocking and layer 1 state logic.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "serial_cfg_params.svh"
module serial_cfg (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic [`ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic IRQ,
  input wire logic CABLE_PRESENT,
  input wire logic CABLE_AUTODETECT,
  input wire logic [3:0] CABLE_IFTYPE,
  input wire logic CABLE_IS_DCE,
  input wire logic PARTNER_IND,
  input wire logic LINK_TXC_IN,
  input wire logic LINK_RXC_IN,
  output logic LINK_TXC_OUT,
  output logic LINK_TXC_OE,
  output logic LINK_RXC_OUT,
  output logic LINK_RXC_OE,
  output logic DCE_PINMAP,
  output logic PORT_ACTIVE,
  output logic LINE_LAYER1_STATE,
  output logic [7:0] HDLC_CMD_ADDR,
  output logic TX_BIT_EN,
  output logic RX_BIT_EN
);
  logic [31:0] config_reg;
  logic [3:0] rate_sel_reg;
  logic [31:0] custom_rate_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic [31:0] rdata_reg;
  serial_cfg_pkg::detect_t detect;
  serial_cfg_pkg::iftype_t if_manual;
  serial_cfg_pkg::role_t role_manual;
  serial_cfg_pkg::l2mode_t l2mode;
  logic leads_en;
  assign detect = serial_cfg_pkg::detect_t'(config_reg[`CFG_DETECT_LSB +: 2]);
  assign if_manual = serial_cfg_pkg::iftype_t'(config_reg[`CFG_IFTYPE_LSB +: 4]);
  assign role_manual = serial_cfg_pkg::role_t'(config_reg[`CFG_ROLE_LSB +: 2]);
  assign l2mode = serial_cfg_pkg::l2mode_t'(config_reg[`CFG_L2MODE_LSB +: 2]);
  assign leads_en = config_reg[`CFG_LEADS_BIT];

  // Every pin from the cable or partner passes two flops before use.
  // The two cable sense pins are combined only after the second flop, never before.
  logic [9:0] pin_meta_reg;
  logic [9:0] pin_sync_reg;
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pin_meta_reg <= 10'h000;
      pin_sync_reg <= 10'h000;
    end else begin
      pin_meta_reg <= {LINK_RXC_IN, LINK_TXC_IN, PARTNER_IND, CABLE_IS_DCE, CABLE_IFTYPE,
                       CABLE_AUTODETECT, CABLE_PRESENT};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  logic cable_ok;
  logic [3:0] cable_if;
  logic cable_dce;
  logic partner_ind_s;
  logic txc_s;
  logic rxc_s;
  assign cable_ok = pin_sync_reg[0] & pin_sync_reg[1];
  assign cable_if = pin_sync_reg[5:2];
  assign cable_dce = pin_sync_reg[6];
  assign partner_ind_s = pin_sync_reg[7];
  assign txc_s = pin_sync_reg[8];
  assign rxc_s = pin_sync_reg[9];

  // Effective interface type and role after detection.
  serial_cfg_pkg::iftype_t if_eff;
  serial_cfg_pkg::role_t role_eff;
  logic det_if;
  logic det_role;
  always_comb begin
    det_if = (detect == serial_cfg_pkg::DET_BOTH) ||
             (detect == serial_cfg_pkg::DET_IFTYPE);
    det_role = (detect == serial_cfg_pkg::DET_BOTH) ||
               (detect == serial_cfg_pkg::DET_ROLE);
    if (!det_if) begin
      if_eff = if_manual;
    end else if (!cable_ok) begin
      if_eff = serial_cfg_pkg::IF_UNKNOWN;
    end else if (cable_if == serial_cfg_pkg::IF_X21_UNTERM) begin
      if_eff = serial_cfg_pkg::IF_X21_TERM;
    end else if (cable_if == serial_cfg_pkg::IF_NONE || cable_if > 4'h8) begin
      if_eff = serial_cfg_pkg::IF_UNKNOWN;
    end else begin
      if_eff = serial_cfg_pkg::iftype_t'(cable_if);
    end
    if (!det_role) begin
      role_eff = role_manual;
    end else if (!cable_ok) begin
      role_eff = serial_cfg_pkg::ROLE_UNKNOWN;
    end else begin
      role_eff = cable_dce ? serial_cfg_pkg::ROLE_DCE : serial_cfg_pkg::ROLE_DTE;
    end
  end
  logic port_used;
  logic is_dce;
  logic is_dte;
  assign port_used = (if_eff != serial_cfg_pkg::IF_NONE) &&
                     (if_eff != serial_cfg_pkg::IF_UNKNOWN);
  assign is_dce = port_used && (role_eff == serial_cfg_pkg::ROLE_DCE);
  assign is_dte = port_used && (role_eff == serial_cfg_pkg::ROLE_DTE);

  // Rate table; selection 13 is the custom rate, whose register ignores writes outside its legal span.
  logic [31:0] rate_bps;
  always_comb begin
    unique case (rate_sel_reg)
      4'h0: rate_bps = 32'h0000_0960;
      4'h1: rate_bps = 32'h0000_2580;
      4'h2: rate_bps = 32'h0000_3840;
      4'h3: rate_bps = 32'h0000_4B00;
      4'h4: rate_bps = 32'h0000_9600;
      4'h5: rate_bps = 32'h0000_FA00;
      4'h6: rate_bps = 32'h0001_F400;
      4'h7: rate_bps = 32'h0003_E800;
      4'h8: rate_bps = 32'h0007_D000;
      4'h9: rate_bps = 32'h000F_4240;
      4'hA: rate_bps = 32'h001E_8480;
      4'hB: rate_bps = 32'h003D_0900;
      4'hC: rate_bps = 32'h007A_1200;
      default: rate_bps = custom_rate_reg;
    endcase
  end

  rate_gen_if rg ();
  assign rg.enable = is_dce;
  assign rg.rate_bps = rate_bps;
  rate_gen #(.CLK_HZ(`CLK_HZ)) u_rate_gen (
    .clk(MCLK),
    .rst(SYS_RST),
    .rg(rg.gen)
  );

  // Line clock: generated in DCE role, sampled edges of partner clocks in DTE role.
  logic line_clk_reg;
  logic txc_d_reg;
  logic rxc_d_reg;
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      line_clk_reg <= 1'b0;
      txc_d_reg <= 1'b0;
      rxc_d_reg <= 1'b0;
    end else begin
      txc_d_reg <= txc_s;
      rxc_d_reg <= rxc_s;
      if (!is_dce) begin
        line_clk_reg <= 1'b0;
      end else if (rg.tick) begin
        line_clk_reg <= ~line_clk_reg;
      end
    end
  end
  // Bit enables mark the rising edge of whichever clock is in charge.
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      TX_BIT_EN <= 1'b0;
      RX_BIT_EN <= 1'b0;
    end else if (is_dce) begin
      TX_BIT_EN <= rg.tick && !line_clk_reg;
      RX_BIT_EN <= rg.tick && !line_clk_reg;
    end else if (is_dte) begin
      TX_BIT_EN <= txc_s && !txc_d_reg;
      RX_BIT_EN <= rxc_s && !rxc_d_reg;
    end else begin
      TX_BIT_EN <= 1'b0;
      RX_BIT_EN <= 1'b0;
    end
  end
  // Pin direction follows the role; unused port keeps its drivers off.
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      LINK_TXC_OUT <= 1'b0;
      LINK_RXC_OUT <= 1'b0;
      LINK_TXC_OE <= 1'b0;
      LINK_RXC_OE <= 1'b0;
      DCE_PINMAP <= 1'b0;
      PORT_ACTIVE <= 1'b0;
    end else begin
      LINK_TXC_OUT <= is_dce && line_clk_reg;
      LINK_RXC_OUT <= is_dce && line_clk_reg;
      LINK_TXC_OE <= is_dce;
      LINK_RXC_OE <= is_dce;
      DCE_PINMAP <= is_dce;
      PORT_ACTIVE <= port_used;
    end
  end

  // Layer 1 state and HDLC command address.
  logic l1_next;
  logic [7:0] addr_next;
  always_comb begin
    if (!leads_en) begin
      l1_next = 1'b1;
    end else begin
      l1_next = partner_ind_s && port_used;
    end
    unique case (l2mode)
      serial_cfg_pkg::L2_DTE: addr_next = `HDLC_ADDR_DTE;
      serial_cfg_pkg::L2_DCE: addr_next = `HDLC_ADDR_DCE;
      default: addr_next = (role_eff == serial_cfg_pkg::ROLE_DCE) ? `HDLC_ADDR_DCE
                                                                 : `HDLC_ADDR_DTE;
    endcase
  end
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      LINE_LAYER1_STATE <= 1'b1;
      HDLC_CMD_ADDR <= `HDLC_ADDR_DTE;
    end else begin
      LINE_LAYER1_STATE <= l1_next;
      HDLC_CMD_ADDR <= addr_next;
    end
  end

  // Events: layer 1 state change and cable status change.
  logic cable_d_reg;
  logic [1:0] events;
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cable_d_reg <= 1'b0;
    end else begin
      cable_d_reg <= cable_ok;
    end
  end
  assign events[`IRQ_L1_CHANGE] = l1_next != LINE_LAYER1_STATE;
  assign events[`IRQ_CABLE_CHANGE] = cable_ok != cable_d_reg;

  // Configuration writes. Partner should use the same lead setting; not enforced here.
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      config_reg <= `CFG_RESET;
      rate_sel_reg <= `RATE_SEL_RESET;
      custom_rate_reg <= `CUSTOM_RATE_RESET;
      irq_mask_reg <= 2'h0;
    end else if (WR) begin
      if (ADDR == `OFF_CONFIG) begin
        config_reg <= {21'h0, WDATA[10:0]};
      end
      if (ADDR == `OFF_RATE_SEL && WDATA[3:0] <= 4'hD) begin
        rate_sel_reg <= WDATA[3:0];
      end
      if (ADDR == `OFF_CUSTOM_RATE && WDATA >= `RATE_MIN_BPS && WDATA <= `RATE_MAX_BPS) begin
        custom_rate_reg <= WDATA;
      end
      if (ADDR == `OFF_IRQ_MASK) begin
        irq_mask_reg <= WDATA[1:0];
      end
    end
  end
  // Set wins over a same-cycle write-one clear.
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_stat_reg <= 2'h0;
    end else if (WR && ADDR == `OFF_IRQ_STAT) begin
      irq_stat_reg <= (irq_stat_reg & ~WDATA[1:0]) | events;
    end else begin
      irq_stat_reg <= irq_stat_reg | events;
    end
  end
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Reads answer one cycle later; unmapped offsets read zero.
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_reg <= 32'h0;
    end else if (RD) begin
      unique case (ADDR)
        `OFF_CONFIG: rdata_reg <= config_reg;
        `OFF_RATE_SEL: rdata_reg <= {28'h0, rate_sel_reg};
        `OFF_CUSTOM_RATE: rdata_reg <= custom_rate_reg;
        `OFF_STATUS: begin
          rdata_reg <= {22'h0, port_used, LINE_LAYER1_STATE, role_eff, if_eff, det_role, det_if};
        end
        `OFF_IRQ_STAT: rdata_reg <= {30'h0, irq_stat_reg};
        `OFF_IRQ_MASK: rdata_reg <= {30'h0, irq_mask_reg};
        `OFF_HDLC_ADDR: rdata_reg <= {24'h0, HDLC_CMD_ADDR};
        default: rdata_reg <= 32'h0;
      endcase
    end else begin
      rdata_reg <= 32'h0;
    end
  end
  assign RDATA = rdata_reg;
endmodule // serial_cfg

// *** tb/line_partner.sv ***
// Far-side line equipment that supplies the line clocks while the port is DTE.
`timescale 1ns/1ps
module line_partner (
  input wire logic run,
  input wire logic txc_out,
  input wire logic txc_oe,
  input wire logic rxc_out,
  input wire logic rxc_oe
  ,
  output logic txc_wire,
  output logic rxc_wire
);
  logic clk_reg = 1'b0;
  // The far clock runs only while run is high and stands still otherwise.
  initial begin
    #7;
    forever #80 if (run) clk_reg = ~clk_reg;
  end
  // Each wire shows whichever party drives it, so no stale value hides.
  assign txc_wire = txc_oe ? txc_out : clk_reg;
  assign rxc_wire = rxc_oe ? rxc_out : clk_reg;
endmodule // line_partner

// *** tb/serial_cfg_monitor.sv ***
// Concurrent checks on the ports of the serial port configuration block.
`timescale 1ns/1ps
`include "serial_cfg_params.svh"
module serial_cfg_monitor (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic [`ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic PARTNER_IND,
  input wire logic LINK_TXC_IN,
  input wire logic LINK_TXC_OE,
  input wire logic LINK_RXC_OE,
  input wire logic DCE_PINMAP,
  input wire logic LINE_LAYER1_STATE,
  input wire logic [7:0] HDLC_CMD_ADDR,
  input wire logic TX_BIT_EN,
  input wire logic RX_BIT_EN
);
  logic leads_reg;
  logic [2:0] lcnt_reg;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // Shadow of the lead checking bit; the count hides the settling after a write.
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      leads_reg <= 1'b0;
      lcnt_reg <= 3'h0;
    end else if (WR && ADDR == `OFF_CONFIG) begin
      leads_reg <= WDATA[`CFG_LEADS_BIT];
      lcnt_reg <= 3'h0;
    end else if (lcnt_reg != 3'h7) begin
      lcnt_reg <= lcnt_reg + 3'h1;
    end
  end
  chk_hdlc_addr_legal: assert property (
    HDLC_CMD_ADDR == `HDLC_ADDR_DTE || HDLC_CMD_ADDR == `HDLC_ADDR_DCE)
    else $error("command address is neither role value");
  chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data outside the answer cycle");
  chk_oe_on_dce: assert property (
    $rose(DCE_PINMAP) |-> ##[0:2] (LINK_TXC_OE && LINK_RXC_OE))
    else $error("clock pins not driven in the DCE role");
  chk_oe_off_dte: assert property (
    $fell(DCE_PINMAP) |-> ##[0:2] !(LINK_TXC_OE || LINK_RXC_OE))
    else $error("clock pins still driven after leaving DCE");
  chk_oe_paired: assert property (LINK_TXC_OE == LINK_RXC_OE)
    else $error("clock enables disagree");
  chk_tx_en_pulse: assert property (TX_BIT_EN |=> !TX_BIT_EN)
    else $error("transmit bit enable longer than one cycle");
  chk_rx_en_pulse: assert property (RX_BIT_EN |=> !RX_BIT_EN)
    else $error("receive bit enable longer than one cycle");
  chk_dte_quiet_clock: assert property (
    (!LINK_TXC_OE && $stable(LINK_TXC_IN)) [*6] |-> !TX_BIT_EN)
    else $error("bit enable without a partner clock edge");
  chk_leads_off_up: assert property (!leads_reg && lcnt_reg == 3'h7 |-> LINE_LAYER1_STATE)
    else $error("layer 1 down with lead checking off");
  chk_leads_ind_down: assert property (
    (leads_reg && lcnt_reg == 3'h7 && !PARTNER_IND) [*6] |=> !LINE_LAYER1_STATE)
    else $error("layer 1 up while partner indication low");
  cov_dce_clock: cover property (LINK_TXC_OE && TX_BIT_EN);
  cov_dte_clock: cover property (!LINK_TXC_OE && TX_BIT_EN);
  cov_l1_drop: cover property ($fell(LINE_LAYER1_STATE));
endmodule // serial_cfg_monitor

// *** tb/test_serial_cfg.sv ***
// Self-checking bench for the serial port configuration block.
`timescale 1ns/1ps
`include "serial_cfg_params.svh"
module test_serial_cfg;
  logic MCLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [`ADDR_W-1:0] ADDR = '0;
  logic [31:0] WDATA = '0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic CABLE_PRESENT = 1'b0;
  logic CABLE_AUTODETECT = 1'b0;
  logic [3:0] CABLE_IFTYPE = 4'h0;
  logic CABLE_IS_DCE = 1'b0;
  logic PARTNER_IND = 1'b0;
  logic run = 1'b0;
  logic [31:0] RDATA, rd_v;
  logic IRQ, LINK_TXC_IN, LINK_RXC_IN, LINK_TXC_OUT, LINK_TXC_OE, LINK_RXC_OUT, LINK_RXC_OE;
  logic DCE_PINMAP, PORT_ACTIVE, LINE_LAYER1_STATE, TX_BIT_EN, RX_BIT_EN;
  logic [7:0] HDLC_CMD_ADDR;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int tx_n = 0;
  int clk_n = 0;
  serial_cfg u_dut (.MCLK, .SYS_RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ, .CABLE_PRESENT,
    .CABLE_AUTODETECT, .CABLE_IFTYPE, .CABLE_IS_DCE, .PARTNER_IND, .LINK_TXC_IN, .LINK_RXC_IN,
    .LINK_TXC_OUT, .LINK_TXC_OE, .LINK_RXC_OUT, .LINK_RXC_OE, .DCE_PINMAP, .PORT_ACTIVE,
    .LINE_LAYER1_STATE, .HDLC_CMD_ADDR, .TX_BIT_EN, .RX_BIT_EN);
  line_partner u_far (.run, .txc_out(LINK_TXC_OUT), .txc_oe(LINK_TXC_OE),
    .rxc_out(LINK_RXC_OUT), .rxc_oe(LINK_RXC_OE), .txc_wire(LINK_TXC_IN), .rxc_wire(LINK_RXC_IN));
  // The clock at 50 MHz.
  initial forever #10 MCLK = ~MCLK;
  // Pulse counting and the hang limit; the limit sits above the longest run.
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (TX_BIT_EN === 1'b1) tx_n <= tx_n + 1;
    if (cyc == 90000) begin
      failures++;
      print_verdict();
    end
  end
  // Edges of the generated line clock.
  always @(posedge LINK_TXC_OUT) clk_n <= clk_n + 1;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge MCLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task rd(input logic [`ADDR_W-1:0] a);
    @(posedge MCLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 rd_v = RDATA;
  endtask
  task wt(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] d, input logic [3:0] i,
    input logic [1:0] r, input logic [1:0] m, input logic l);
    return {21'h0, l, m, r, i, d};
  endfunction
  // Counts bit enables, and in DCE also line clock edges, against a figure.
  task meas(input int n, input int e, input logic dce);
    int c;
    #1 tx_n = 0;
    clk_n = 0;
    wt(n);
    c = dce ? clk_n : e;
    check(32'(tx_n >= e - 2 && tx_n <= e + 2 && c >= e - 2 && c <= e + 2), 32'h1);
  endtask
  task t_reset();
    rd(`OFF_RATE_SEL);
    check(rd_v, 32'h5);
    rd(`OFF_CUSTOM_RATE);
    check(rd_v, 32'd64000);
    check(LINE_LAYER1_STATE, 1'b1);
    check(HDLC_CMD_ADDR, 8'h03);
    wr(4'hF, 32'hFFFF_FFFF);
    rd(4'hF);
    check(rd_v, 32'h0);
    wr(`OFF_HDLC_ADDR, 32'hFF);
    rd(`OFF_HDLC_ADDR);
    check(rd_v, 32'h3);
  endtask
  task t_rates();
    int rt[13] = '{2400, 9600, 14400, 19200, 38400, 64000, 128000, 256000, 512000,
      1000000, 2000000, 4000000, 8000000};
    wr(`OFF_CONFIG, cfg(2'h3, 4'h3, 2'h2, 2'h0, 1'b0));
    for (int s = 0; s < 14; s++) begin
      wr(`OFF_RATE_SEL, 32'(s));
      rd(`OFF_RATE_SEL);
      check(rd_v, 32'(s));
      if (s > 4 && s < 13) meas(5000, rt[s] / 10000, 1'b1);
    end
    wr(`OFF_RATE_SEL, 32'hE);
    rd(`OFF_RATE_SEL);
    check(rd_v, 32'hD);
    wr(`OFF_CUSTOM_RATE, 32'd2399);
    wr(`OFF_CUSTOM_RATE, 32'd8000001);
    rd(`OFF_CUSTOM_RATE);
    check(rd_v, 32'd64000);
    wr(`OFF_CUSTOM_RATE, 32'd2400);
    rd(`OFF_CUSTOM_RATE);
    check(rd_v, 32'd2400);
    wr(`OFF_CUSTOM_RATE, 32'd1000000);
    meas(5000, 100, 1'b1);
    wr(`OFF_CONFIG, cfg(2'h3, 4'h3, 2'h1, 2'h0, 1'b0));
    wt(6);
    check(LINK_TXC_OE, 1'b0);
    meas(1000, 0, 1'b0);
    run = 1'b1;
    meas(1000, 125, 1'b0);
    run = 1'b0;
  endtask
  task t_l2();
    logic [7:0] e;
    for (int r = 1; r < 3; r++)
      for (int m = 0; m < 3; m++) begin
        wr(`OFF_CONFIG, cfg(2'h3, 4'h3, 2'(r), 2'(m), 1'b0));
        wt(6);
        e = (m == 2 || (m == 0 && r == 2)) ? `HDLC_ADDR_DCE : `HDLC_ADDR_DTE;
        check(HDLC_CMD_ADDR, e);
        rd(`OFF_HDLC_ADDR);
        check(rd_v, e);
        check(DCE_PINMAP, r == 2);
      end
  endtask
  task t_leads();
    wr(`OFF_IRQ_MASK, 32'h1);
    wr(`OFF_CONFIG, cfg(2'h3, 4'h3, 2'h1, 2'h0, 1'b1));
    PARTNER_IND <= 1'b1;
    wt(6);
    check(LINE_LAYER1_STATE, 1'b1);
    wr(`OFF_IRQ_STAT, 32'h3);
    PARTNER_IND <= 1'b0;
    wt(6);
    check(LINE_LAYER1_STATE, 1'b0);
    check(IRQ, 1'b1);
    wr(`OFF_IRQ_MASK, 32'h0);
    wt(3);
    check(IRQ, 1'b0);
    wr(`OFF_IRQ_STAT, 32'h1);
    rd(`OFF_IRQ_STAT);
    check(rd_v, 32'h0);
    wr(`OFF_CONFIG, cfg(2'h3, 4'h1, 2'h1, 2'h0, 1'b0));
    wt(6);
    check(LINE_LAYER1_STATE, 1'b1);
    check(PORT_ACTIVE, 1'b0);
  endtask
  // One cable and detection setting, then the reported type and role.
  task det(input logic [1:0] d, input logic p, input logic a, input logic [3:0] t,
    input logic c, input logic [3:0] mi, input logic [3:0] ei, input logic [1:0] er);
    CABLE_PRESENT <= p;
    CABLE_AUTODETECT <= a;
    CABLE_IFTYPE <= t;
    CABLE_IS_DCE <= c;
    wr(`OFF_CONFIG, cfg(d, mi, 2'h2, 2'h0, 1'b0));
    wt(8);
    rd(`OFF_STATUS);
    check(rd_v[7:0], {er, ei, ~d[0], ~d[1]});
    check(DCE_PINMAP, er == 2'h2);
  endtask
  initial begin
    repeat (20) @(posedge MCLK);
    SYS_RST <= 1'b0;
    t_reset();
    t_rates();
    t_l2();
    t_leads();
    det(2'h0, 1'b1, 1'b1, 4'h6, 1'b1, 4'h4, 4'h2, 2'h2);
    det(2'h0, 1'b1, 1'b1, 4'h3, 1'b0, 4'h4, 4'h3, 2'h1);
    det(2'h0, 1'b0, 1'b1, 4'h3, 1'b0, 4'h4, 4'h0, 2'h0);
    det(2'h0, 1'b1, 1'b0, 4'h3, 1'b0, 4'h4, 4'h0, 2'h0);
    det(2'h1, 1'b1, 1'b1, 4'h3, 1'b0, 4'h4, 4'h3, 2'h2);
    det(2'h2, 1'b1, 1'b1, 4'h3, 1'b0, 4'h4, 4'h4, 2'h1);
    det(2'h3, 1'b1, 1'b1, 4'h3, 1'b0, 4'h6, 4'h6, 2'h2);
    rd(`OFF_IRQ_STAT);
    check(rd_v[1], 1'b1);
    print_verdict();
  end
  task print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
endmodule // test_serial_cfg
bind serial_cfg serial_cfg_monitor u_mon (.MCLK, .SYS_RST, .ADDR, .WDATA, .WR, .RD, .RDATA,
  .PARTNER_IND, .LINK_TXC_IN, .LINK_TXC_OE, .LINK_RXC_OE, .DCE_PINMAP, .LINE_LAYER1_STATE,
  .HDLC_CMD_ADDR, .TX_BIT_EN, .RX_BIT_EN);
